// ==== src/cpm_pin_mux.sv ====
`timescale 1ns/100ps
// Overview of operation
// - strap 00 mux,01 nonmux,10 serial,11 hardware
// - nonmux mode: shared pins are data bits
// - mux mode: shared pins are data bits only; bus address held zero
// - serial mode: bit0 pin drives read data
// - bit1 pin takes serial write data
// - nonmux mode: address from seven address pins
// - serial mode: address bit5 gives clock polarity
// - serial mode: address bit4 gives clock phase
// - hardware mode: bit1 pin is rx mode 3
// - hardware mode: address bit5 is tx mode 0
// - hardware mode: address bits 4..2 give build-out
// - hardware mode: address bit6 is prescale 0
// - tx clock source from bit0 and pin
// - alarm pattern sent while alarm pin low
// - alarm pin ignored outside T1/E1 modes
// - hardware mode termination 0=75, 1=120 ohm
module cpm_pin_mux #(
    parameter int ADDR_W = cpm_pkg::ADDR_WIDTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] interface_mode_strap,
    input wire logic [1:0] ad_in,
    output logic [1:0] ad_out,
    output logic [1:0] ad_oe,
    input wire logic [ADDR_W-1:0] addr_pin,
    input wire logic tx_clk_src_sel_1,
    input wire logic [1:0] tx_op_mode,
    input wire logic [1:0] bus_rd_data,
    input wire logic bus_rd_en,
    input wire logic spi_miso_data,
    input wire logic spi_miso_en,
    output logic [1:0] mode,
    output logic [1:0] bus_data_in,
    output logic [ADDR_W-1:0] bus_addr,
    output logic spi_mosi,
    output logic spi_cpol,
    output logic spi_cpha,
    output logic rx_mode_sel_3,
    output logic tx_mode_sel_0,
    output logic [2:0] build_out_sel,
    output logic pll_prescale_sel_0,
    output logic [1:0] tx_clk_src_sel,
    output logic send_alarm,
    output logic e1_termination_sel
);
    // Refuse at elaboration any address width other than the seven bits that the fixed pin roles use.
    if (ADDR_W != cpm_pkg::ADDR_WIDTH) begin : g_bad_addr_w
        $error("cpm_pin_mux: address width must be seven");
    end

    logic rst_sync_n;
    cpm_sync2 u_rst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .q(rst_sync_n)
    );

    // Decoding of the strap, used for every pin role below except the clock source and alarm.
    function automatic cpm_pkg::cpm_mode_e decode_mode(input logic [1:0] s);
        cpm_pkg::cpm_mode_e m;
        m = cpm_pkg::CPM_HW;
        if (s == cpm_pkg::MODE_MUX) begin
            m = cpm_pkg::CPM_MUX;
        end else if (s == cpm_pkg::MODE_NONMUX) begin
            m = cpm_pkg::CPM_NONMUX;
        end else if (s == cpm_pkg::MODE_SERIAL) begin
            m = cpm_pkg::CPM_SERIAL;
        end
        return m;
    endfunction

    cpm_pkg::cpm_mode_e md;
    assign md = decode_mode(interface_mode_strap);

    logic [1:0] mode_reg, mode_next;
    logic [1:0] ad_out_reg, ad_out_next;
    logic [1:0] ad_oe_reg, ad_oe_next;
    logic [1:0] din_reg, din_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic mosi_reg, mosi_next;
    logic cpol_reg, cpol_next;
    logic cpha_reg, cpha_next;
    logic rxm3_reg, rxm3_next;
    logic txm0_reg, txm0_next;
    logic [2:0] lbo_reg, lbo_next;
    logic pll_prescale_sel_0_reg, pll_prescale_sel_0_next;
    logic [1:0] tcs_reg, tcs_next;
    logic ais_reg, ais_next;
    logic term_reg, term_next;

    // Each pin except the bit0 and alarm pins is given only the role of the current mode; others hold zero so
    // that downstream logic never acts on a stale role after a strap change.
    always_comb begin
        mode_next = interface_mode_strap;
        ad_out_next = 2'h0;
        ad_oe_next = 2'h0;
        din_next = 2'h0;
        addr_next = '0;
        mosi_next = 1'b0;
        cpol_next = 1'b0;
        cpha_next = 1'b0;
        rxm3_next = 1'b0;
        txm0_next = 1'b0;
        lbo_next = 3'h0;
        pll_prescale_sel_0_next = 1'b0;
        term_next = cpm_pkg::TERM_75_OHM;
        // The clock-source select is read in every mode.
        tcs_next = {tx_clk_src_sel_1, ad_in[cpm_pkg::DATA_BIT0]};
        // Alarm only in T1/E1 operating modes, and only while the pin is low.
        ais_next = 1'b0;
        if (tx_op_mode == cpm_pkg::TXOP_T1 || tx_op_mode == cpm_pkg::TXOP_E1) begin
            ais_next = ~addr_pin[cpm_pkg::ADDR_AIS];
        end
        case (md)
            cpm_pkg::CPM_MUX: begin
                // Dedicated address pins are expected tied low; only the alarm pin among them is read.
                din_next = ad_in;
                ad_out_next = bus_rd_data;
                ad_oe_next = {2{bus_rd_en}};
            end
            cpm_pkg::CPM_NONMUX: begin
                din_next = ad_in;
                addr_next = addr_pin;
                ad_out_next = bus_rd_data;
                ad_oe_next = {2{bus_rd_en}};
            end
            cpm_pkg::CPM_SERIAL: begin
                mosi_next = ad_in[cpm_pkg::DATA_BIT1];
                ad_out_next[cpm_pkg::DATA_BIT0] = spi_miso_data;
                ad_oe_next[cpm_pkg::DATA_BIT0] = spi_miso_en;
                cpol_next = addr_pin[cpm_pkg::ADDR_CPOL];
                cpha_next = addr_pin[cpm_pkg::ADDR_CPHA];
            end
            default: begin
                rxm3_next = ad_in[cpm_pkg::DATA_BIT1];
                txm0_next = addr_pin[cpm_pkg::ADDR_CPOL];
                lbo_next = addr_pin[cpm_pkg::ADDR_LBO_HI:cpm_pkg::ADDR_LBO_LO];
                pll_prescale_sel_0_next = addr_pin[cpm_pkg::ADDR_PRESCALE];
                term_next = addr_pin[cpm_pkg::ADDR_TERM];
            end
        endcase
    end

    // Registering every output costs one cycle of latency but keeps ports glitch free.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg <= 2'h0;
            ad_out_reg <= 2'h0;
            ad_oe_reg <= 2'h0;
            din_reg <= 2'h0;
            addr_reg <= '0;
            mosi_reg <= 1'b0;
            cpol_reg <= 1'b0;
            cpha_reg <= 1'b0;
            rxm3_reg <= 1'b0;
            txm0_reg <= 1'b0;
            lbo_reg <= 3'h0;
            pll_prescale_sel_0_reg <= 1'b0;
            tcs_reg <= 2'h0;
            ais_reg <= 1'b0;
            term_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            ad_out_reg <= ad_out_next;
            ad_oe_reg <= ad_oe_next;
            din_reg <= din_next;
            addr_reg <= addr_next;
            mosi_reg <= mosi_next;
            cpol_reg <= cpol_next;
            cpha_reg <= cpha_next;
            rxm3_reg <= rxm3_next;
            txm0_reg <= txm0_next;
            lbo_reg <= lbo_next;
            pll_prescale_sel_0_reg <= pll_prescale_sel_0_next;
            tcs_reg <= tcs_next;
            ais_reg <= ais_next;
            term_reg <= term_next;
        end
    end

    assign mode = mode_reg;
    assign ad_out = ad_out_reg;
    assign ad_oe = ad_oe_reg;
    assign bus_data_in = din_reg;
    assign bus_addr = addr_reg;
    assign spi_mosi = mosi_reg;
    assign spi_cpol = cpol_reg;
    assign spi_cpha = cpha_reg;
    assign rx_mode_sel_3 = rxm3_reg;
    assign tx_mode_sel_0 = txm0_reg;
    assign build_out_sel = lbo_reg;
    assign pll_prescale_sel_0 = pll_prescale_sel_0_reg;
    assign tx_clk_src_sel = tcs_reg;
    assign send_alarm = ais_reg;
    assign e1_termination_sel = term_reg;

    // Checks on the registered pin roles. Each starts only on an edge at which the output
    // flops were already out of reset, so the release edge itself cannot fire them.
    mode_strap_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n |=> mode == $past(interface_mode_strap))
        else $error("mode not strap");
    nonmux_data_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_NONMUX
        |=> bus_data_in == $past(ad_in))
        else $error("nonmux data");
    mux_data_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_MUX
        |=> bus_data_in == $past(ad_in) && bus_addr == '0)
        else $error("mux data");
    miso_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_SERIAL
        |=> ad_out[0] == $past(spi_miso_data) && ad_oe == {1'b0, $past(spi_miso_en)})
        else $error("miso drive");
    mosi_take_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_SERIAL
        |=> spi_mosi == $past(ad_in[1]))
        else $error("mosi");
    nonmux_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_NONMUX
        |=> bus_addr == $past(addr_pin))
        else $error("addr");
    spi_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_SERIAL
        |=> spi_cpol == $past(addr_pin[5]) && spi_cpha == $past(addr_pin[4]))
        else $error("spi clock sel");
    hw_straps_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap == cpm_pkg::MODE_HW
        |=> rx_mode_sel_3 == $past(ad_in[1])
        && tx_mode_sel_0 == $past(addr_pin[5]) && build_out_sel == $past(addr_pin[4:2])
        && pll_prescale_sel_0 == $past(addr_pin[6])
        && e1_termination_sel == $past(addr_pin[0]))
        else $error("hw straps");
    clk_src_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n |=> tx_clk_src_sel == {$past(tx_clk_src_sel_1), $past(ad_in[0])})
        else $error("clk src");
    alarm_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n |=> send_alarm == ($past(tx_op_mode) < 2'h2 && !$past(addr_pin[1])))
        else $error("alarm");
    role_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rst_sync_n && interface_mode_strap != cpm_pkg::MODE_HW
        |=> !rx_mode_sel_3 && build_out_sel == 3'h0)
        else $error("hw roles leak");
endmodule

// ==== src/cpm_pkg.sv ====
package cpm_pkg;
    // Interface mode strap encodings.
    localparam logic [1:0] MODE_MUX = 2'h0;
    localparam logic [1:0] MODE_NONMUX = 2'h1;
    localparam logic [1:0] MODE_SERIAL = 2'h2;
    localparam logic [1:0] MODE_HW = 2'h3;
    // Bit positions on the shared pin groups.
    localparam int DATA_BIT1 = 1;
    localparam int DATA_BIT0 = 0;
    localparam int ADDR_PRESCALE = 6;
    localparam int ADDR_CPOL = 5;
    localparam int ADDR_CPHA = 4;
    localparam int ADDR_LBO_HI = 4;
    localparam int ADDR_LBO_LO = 2;
    localparam int ADDR_AIS = 1;
    localparam int ADDR_TERM = 0;
    localparam int ADDR_WIDTH = 7;
    // Termination encodings: 0 selects 75 ohm, 1 selects 120 ohm.
    localparam logic TERM_75_OHM = 1'b0;
    localparam logic TERM_120_OHM = 1'b1;
    // Transmit operating modes in which the alarm pin acts.
    localparam logic [1:0] TXOP_T1 = 2'h0;
    localparam logic [1:0] TXOP_E1 = 2'h1;
    typedef enum logic [1:0] {CPM_MUX, CPM_NONMUX, CPM_SERIAL, CPM_HW} cpm_mode_e;
endpackage

// ==== src/cpm_sync2.sv ====
`timescale 1ns/100ps
// Two-stage synchroniser for the reset release; the first stage feeds only the second.
module cpm_sync2 (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s1_next;
    logic s2_next;

    // Next values shift in a constant one behind the asserted reset.
    always_comb begin
        s1_next = 1'b1;
        s2_next = s1_reg;
    end

    // Asynchronous assert, synchronous release.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign q = s2_reg;
endmodule

// ==== verif/cpm_host_model.sv ====
`timescale 1ns/100ps
// Host processor and board straps standing on the far side of the shared pins.
module cpm_host_model (
    input wire logic [1:0] interface_mode_strap,
    input wire logic [1:0] ad_out,
    input wire logic [1:0] ad_oe,
    input wire logic [1:0] host_ad,
    input wire logic [6:0] host_addr,
    output logic [1:0] ad_in,
    output logic [6:0] addr_pin
);
    // A shared pin shows the device level where it drives, the host level elsewhere.
    // Every level applied here stands for an access made with chip select held low.
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & host_ad);
    // The board ties the dedicated address pins low in multiplexed mode.
    assign addr_pin = (interface_mode_strap == cpm_pkg::MODE_MUX) ? 7'h00 : host_addr;
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] interface_mode_strap = 2'h0, host_ad = 2'h0, tx_op_mode = 2'h0, bus_rd_data = 2'h0;
    logic [6:0] host_addr = 7'h00;
    logic tx_clk_src_sel_1 = 1'b0, bus_rd_en = 1'b0, spi_miso_data = 1'b0, spi_miso_en = 1'b0;
    logic [1:0] ad_in, ad_out, ad_oe, mode, bus_data_in, tx_clk_src_sel;
    logic [6:0] addr_pin, bus_addr;
    logic spi_mosi, spi_cpol, spi_cpha, rx_mode_sel_3, tx_mode_sel_0, pll_prescale_sel_0;
    logic send_alarm, e1_termination_sel;
    logic [2:0] build_out_sel;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    // A 50 ns period clock.
    always #25 clk_sys = ~clk_sys;

    cpm_pin_mux DUT (.clk_sys, .rst_n, .interface_mode_strap, .ad_in, .ad_out, .ad_oe,
        .addr_pin, .tx_clk_src_sel_1, .tx_op_mode, .bus_rd_data, .bus_rd_en, .spi_miso_data,
        .spi_miso_en, .mode, .bus_data_in, .bus_addr, .spi_mosi, .spi_cpol, .spi_cpha,
        .rx_mode_sel_3, .tx_mode_sel_0, .build_out_sel, .pll_prescale_sel_0, .tx_clk_src_sel,
        .send_alarm, .e1_termination_sel);

    cpm_host_model host (.interface_mode_strap, .ad_out, .ad_oe, .host_ad, .host_addr,
        .ad_in, .addr_pin);

    task automatic stop_test();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Works out every output from the applied levels once the pin feedback has settled.
    task automatic check_all();
        logic [1:0] m, oe, dout, pin;
        logic [6:0] a;
        m = interface_mode_strap;
        a = (m == cpm_pkg::MODE_MUX) ? 7'h00 : host_addr;
        dout = (m == cpm_pkg::MODE_SERIAL) ? {1'b0, spi_miso_data} : bus_rd_data;
        oe = (m == cpm_pkg::MODE_SERIAL) ? {1'b0, spi_miso_en} : 2'h0;
        oe = (m[1] == 1'b0) ? {2{bus_rd_en}} : oe;
        pin = (oe & dout) | (~oe & host_ad);
        check(mode, m);
        check({ad_oe, ad_out & oe}, {oe, dout & oe});
        check(bus_data_in, (m[1] == 1'b0) ? pin : 2'h0);
        check(bus_addr, (m == cpm_pkg::MODE_NONMUX) ? a : 7'h00);
        check({spi_mosi, spi_cpol, spi_cpha},
            (m == cpm_pkg::MODE_SERIAL) ? {pin[1], a[5], a[4]} : 3'h0);
        check({rx_mode_sel_3, tx_mode_sel_0, build_out_sel, pll_prescale_sel_0,
            e1_termination_sel}, (m == cpm_pkg::MODE_HW) ? {pin[1], a[5], a[4:2], a[6], a[0]}
            : 7'h00);
        check(tx_clk_src_sel, {tx_clk_src_sel_1, pin[0]});
        check(send_alarm, (tx_op_mode inside {cpm_pkg::TXOP_T1, cpm_pkg::TXOP_E1})
            && !a[1]);
    endtask

    // Holds one set of levels for three edges so that the pin feedback settles.
    task automatic apply(input logic [1:0] m, input logic [31:0] r);
        @(posedge clk_sys);
        interface_mode_strap <= m;
        host_ad <= r[1:0];
        host_addr <= r[8:2];
        tx_clk_src_sel_1 <= r[9];
        tx_op_mode <= r[11:10];
        bus_rd_data <= r[13:12];
        bus_rd_en <= r[14];
        spi_miso_data <= r[15];
        spi_miso_en <= r[16];
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check_all();
    endtask

    // A hang is cut short well beyond the expected run of about a thousand cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(32'h82ce7d7d));
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Corner levels: all ones and all zeros, each with the alarm pin bit inverted, and every transmit operating mode, in each mode.
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 8; k++) begin
                apply(2'(m), {32{k[0]}} ^ (32'(k[2:1]) << 10) ^ 32'h8);
            end
        end
        repeat (200) apply(2'($urandom_range(3)), $urandom());
        stop_test();
    end
endmodule
